// file: hdl/dpo_top.sv
`timescale 1ns/1ps
`include "dpo_consts.svh"

// Behaviour
// - Two channels driven from 16-bit level cells
// - Each channel has its own enable
// - Resolution programmable from 10 to 16
// - Time base from slow or fast oscillator
// - Channel a on pin 0/2, b 1/3
// - Zero level gives constant low output
// - All-ones level gives constant high output
// - Settings held in registers 27, 29-32, status in 33
// - Slow oscillator always runs, no stop
// - Slow frequency set by coarse/fine trim
// - Run field: off, permanent, latency 1/2/31
// - Divide bit quarters fast clock to 500k
// - Pins 0/2 carry a, 1/3 carry b
module dpo_top
#(
  parameter int unsigned SLOW_DIV_5K = `DPO_MCLK_HZ / `DPO_F_5K
)
(
  // Clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  // Processor write port for level cells
  input  wire logic              proc_wr_in,
  input  wire logic [6:0]        proc_addr_in,
  input  wire dpo_pkg::dpo_word_t proc_data_in,
  // Configuration register port
  input  wire logic              cfg_wr_in,
  input  wire logic              cfg_rd_in,
  input  wire logic [5:0]        cfg_addr_in,
  input  wire dpo_pkg::dpo_word_t cfg_wdata_in,
  output logic [15:0]            cfg_rdata_out,
  output logic                   cfg_rvalid_out,
  // Oscillator status
  output logic                   slow_osc_clock_out,
  output logic                   fast_osc_ready_out,
  // Port pins
  output logic                   port_pin_zero_out,
  output logic                   port_pin_zero_oe_out,
  output logic                   port_pin_one_out,
  output logic                   port_pin_one_oe_out,
  output logic                   port_pin_two_out,
  output logic                   port_pin_two_oe_out,
  output logic                   port_pin_three_out,
  output logic                   port_pin_three_oe_out
);
  import dpo_pkg::*;

  // ***************************************************************
  // Register file
  // ***************************************************************
  dpo_word_t pulse_level_ref_a;
  dpo_word_t pulse_level_ref_b;
  dpo_word_t cfg_osc;
  dpo_word_t cfg_chan_a;
  dpo_word_t cfg_chan_b;
  dpo_word_t cfg_res;
  dpo_word_t cfg_clk;
  dpo_word_t next_level_a;
  dpo_word_t next_level_b;
  dpo_word_t next_cfg_osc;
  dpo_word_t next_cfg_chan_a;
  dpo_word_t next_cfg_chan_b;
  dpo_word_t next_cfg_res;
  dpo_word_t next_cfg_clk;
  dpo_word_t next_rdata;
  logic      next_rvalid;
  dpo_fast_state_t fast_state;
  logic      fast_running;
  dpo_res_t  res_sel;

  // Write decode; level cells are write only from the processor side
  always_comb
  begin
    next_level_a    = pulse_level_ref_a;
    next_level_b    = pulse_level_ref_b;
    next_cfg_osc    = cfg_osc;
    next_cfg_chan_a = cfg_chan_a;
    next_cfg_chan_b = cfg_chan_b;
    next_cfg_res    = cfg_res;
    next_cfg_clk    = cfg_clk;
    if (proc_wr_in && proc_addr_in == `DPO_ADDR_LEVEL_A)
      next_level_a = proc_data_in;
    if (proc_wr_in && proc_addr_in == `DPO_ADDR_LEVEL_B)
      next_level_b = proc_data_in;
    if (cfg_wr_in)
    begin
      unique case (cfg_addr_in)
        `DPO_CFG_OSC:    next_cfg_osc    = cfg_wdata_in;
        `DPO_CFG_CHAN_A: next_cfg_chan_a = cfg_wdata_in;
        `DPO_CFG_CHAN_B: next_cfg_chan_b = cfg_wdata_in;
        `DPO_CFG_RES:    next_cfg_res    = cfg_wdata_in;
        `DPO_CFG_CLK:    next_cfg_clk    = cfg_wdata_in;
        default:         next_cfg_osc    = cfg_osc;       // Status and unmapped ignore writes
      endcase
    end
  end

  // Read mux; unmapped numbers read as zero
  always_comb
  begin
    next_rvalid = cfg_rd_in;
    next_rdata  = 16'h0000;
    if (cfg_rd_in)
    begin
      unique case (cfg_addr_in)
        `DPO_CFG_OSC:    next_rdata = cfg_osc;
        `DPO_CFG_CHAN_A: next_rdata = cfg_chan_a;
        `DPO_CFG_CHAN_B: next_rdata = cfg_chan_b;
        `DPO_CFG_RES:    next_rdata = {11'h000, res_sel};  // Resolution in force
        `DPO_CFG_CLK:    next_rdata = cfg_clk;
        `DPO_CFG_STAT:   next_rdata = {14'h0000, fast_running, fast_state == DPO_FO_RUN};
        default:         next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pulse_level_ref_a <= `DPO_LEVEL_RST;
      pulse_level_ref_b <= `DPO_LEVEL_RST;
      cfg_osc           <= `DPO_CFG_OSC_RST;
      cfg_chan_a        <= `DPO_CFG_CHAN_RST;
      cfg_chan_b        <= `DPO_CFG_CHAN_RST;
      cfg_res           <= `DPO_CFG_RES_RST;
      cfg_clk           <= `DPO_CFG_CLK_RST;
      cfg_rdata_out     <= 16'h0000;
      cfg_rvalid_out    <= 1'b0;
    end
    else
    begin
      pulse_level_ref_a <= next_level_a;
      pulse_level_ref_b <= next_level_b;
      cfg_osc           <= next_cfg_osc;
      cfg_chan_a        <= next_cfg_chan_a;
      cfg_chan_b        <= next_cfg_chan_b;
      cfg_res           <= next_cfg_res;
      cfg_clk           <= next_cfg_clk;
      cfg_rdata_out     <= next_rdata;
      cfg_rvalid_out    <= next_rvalid;
    end
  end

  // ***************************************************************
  // Slow oscillator
  // ***************************************************************
  logic [12:0] slow_cnt;
  logic [12:0] next_slow_cnt;
  logic        slow_tick;
  logic        next_slow_tick;
  logic [12:0] slow_div;

  // Trim pair to divisor; unlisted fine values fall back to the coarse band
  function automatic logic [12:0] slow_divisor(input logic [1:0] ct, input logic [2:0] ft);
    logic [12:0] d;
    d = 13'(`DPO_MCLK_HZ / `DPO_F_50K);
    unique case (ct)
      2'd3: d = (ft == 3'd1) ? 13'(SLOW_DIV_5K) : 13'(`DPO_MCLK_HZ / `DPO_F_10K);
      2'd2: d = (ft == 3'd0) ? 13'(`DPO_MCLK_HZ / `DPO_F_28K) :
                (ft == 3'd3) ? 13'(`DPO_MCLK_HZ / `DPO_F_48K) :
                               13'(`DPO_MCLK_HZ / `DPO_F_50K);
      2'd1: d = 13'(`DPO_MCLK_HZ / `DPO_F_100K);
      2'd0: d = 13'(`DPO_MCLK_HZ / `DPO_F_200K);
    endcase
    slow_divisor = d;
  endfunction

  // Free running from reset; no control bit can halt it
  always_comb
  begin
    slow_div = slow_divisor(cfg_osc[`DPO_OSC_CTUNE_LSB +: 2],
                            cfg_osc[`DPO_OSC_FTUNE_LSB +: 3]);
    next_slow_tick = 1'b0;
    next_slow_cnt  = slow_cnt + 13'h0001;
    if (slow_cnt >= slow_div - 13'h0001)
    begin
      next_slow_cnt  = 13'h0000;
      next_slow_tick = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      slow_cnt  <= 13'h0000;
      slow_tick <= 1'b0;
    end
    else
    begin
      slow_cnt  <= next_slow_cnt;
      slow_tick <= next_slow_tick;
    end
  end

  // ***************************************************************
  // Fast oscillator run control and divider
  // ***************************************************************
  dpo_fast_state_t next_fast_state;
  logic [2:0]  run_seen;
  logic [4:0]  lat_cnt;
  logic [4:0]  next_lat_cnt;
  logic [4:0]  frac;
  logic [4:0]  next_frac;
  logic [1:0]  quarter;
  logic [1:0]  next_quarter;
  logic        fast_tick;
  logic        next_fast_tick;
  logic [2:0]  run_sel;
  logic [5:0]  frac_sum;

  // Any change of the run field restarts the sequence
  always_comb
  begin
    run_sel         = cfg_osc[`DPO_OSC_RUN_LSB +: 3];
    next_fast_state = fast_state;
    next_lat_cnt    = lat_cnt;
    if (run_sel != run_seen)
    begin
      unique case (run_sel)
        3'd1:    next_fast_state = DPO_FO_RUN;
        3'd6:    begin next_fast_state = DPO_FO_WAIT; next_lat_cnt = 5'(`DPO_LAT_1); end
        3'd3:    begin next_fast_state = DPO_FO_WAIT; next_lat_cnt = 5'(`DPO_LAT_2); end
        3'd2:    begin next_fast_state = DPO_FO_WAIT; next_lat_cnt = 5'(`DPO_LAT_31); end
        default: next_fast_state = DPO_FO_OFF;
      endcase
    end
    else if (fast_state == DPO_FO_WAIT && slow_tick)
    begin
      // Latency counted in slow periods before the time base may use it
      next_lat_cnt = lat_cnt - 5'd1;
      if (lat_cnt == 5'd1)
        next_fast_state = DPO_FO_RUN;
    end
    fast_running = fast_state != DPO_FO_OFF;
    // Fractional step: 2 MHz is not an integer divide of the master clock
    frac_sum       = {1'b0, frac} + 6'(`DPO_FAST_STEP);
    next_frac      = frac;
    next_quarter   = quarter;
    next_fast_tick = 1'b0;
    if (fast_running)
    begin
      next_frac = frac_sum[4:0];
      if (frac_sum >= 6'(`DPO_FAST_MOD))
      begin
        next_frac    = 5'(frac_sum - 6'(`DPO_FAST_MOD));
        next_quarter = quarter + 2'd1;
        next_fast_tick = cfg_osc[`DPO_OSC_DIV4_BIT] ? (quarter == 2'd3) : 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      fast_state <= DPO_FO_OFF;
      run_seen   <= 3'd0;
      lat_cnt    <= 5'd0;
      frac       <= 5'd0;
      quarter    <= 2'd0;
      fast_tick  <= 1'b0;
    end
    else
    begin
      fast_state <= next_fast_state;
      run_seen   <= run_sel;
      lat_cnt    <= next_lat_cnt;
      frac       <= next_frac;
      quarter    <= next_quarter;
      fast_tick  <= next_fast_tick;
    end
  end

  // ***************************************************************
  // Time base selection and prescaler
  // ***************************************************************
  logic [6:0] pre_cnt;
  logic [6:0] next_pre_cnt;
  logic       base_tick;
  logic       next_base_tick;
  logic       src_tick;
  logic [6:0] pre_mask;

  // Fast source only counts once its latency has elapsed
  always_comb
  begin
    src_tick = cfg_clk[`DPO_CLK_SRC_BIT] ? (fast_tick && fast_state == DPO_FO_RUN)
                                         : slow_tick;
    pre_mask       = 7'(8'h7f >> (3'd7 - cfg_clk[`DPO_CLK_PRE_LSB +: 3]));
    pre_mask       = (cfg_clk[`DPO_CLK_PRE_LSB +: 3] == 3'd0) ? 7'h00 : pre_mask;
    next_pre_cnt   = pre_cnt;
    next_base_tick = 1'b0;
    if (src_tick)
    begin
      next_pre_cnt   = (pre_cnt + 7'h01) & pre_mask;
      next_base_tick = (pre_cnt & pre_mask) == pre_mask;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pre_cnt   <= 7'h00;
      base_tick <= 1'b0;
    end
    else
    begin
      pre_cnt   <= next_pre_cnt;
      base_tick <= next_base_tick;
    end
  end

  // ***************************************************************
  // Channels and pin routing
  // ***************************************************************
  dpo_chan_if ch_a ();
  dpo_chan_if ch_b ();

  // Out-of-range resolution codes clamp to the nearest legal value
  always_comb
  begin
    res_sel = cfg_res[`DPO_RES_LSB +: 5];
    if (res_sel < 5'(`DPO_RES_MIN))
      res_sel = 5'(`DPO_RES_MIN);
    else if (res_sel > 5'(`DPO_RES_MAX))
      res_sel = 5'(`DPO_RES_MAX);
  end

  assign ch_a.tick     = base_tick;
  assign ch_a.enable   = cfg_chan_a[`DPO_CH_EN_BIT];
  assign ch_a.pdm_mode = cfg_chan_a[`DPO_CH_PDM_BIT];
  assign ch_a.res      = res_sel;
  assign ch_a.level    = pulse_level_ref_a;
  assign ch_b.tick     = base_tick;
  assign ch_b.enable   = cfg_chan_b[`DPO_CH_EN_BIT];
  assign ch_b.pdm_mode = cfg_chan_b[`DPO_CH_PDM_BIT];
  assign ch_b.res      = res_sel;
  assign ch_b.level    = pulse_level_ref_b;

  dpo_chan u_chan_a (.mclk_in(mclk_in), .rstn_in(rstn_in), .bus(ch_a.chan));
  dpo_chan u_chan_b (.mclk_in(mclk_in), .rstn_in(rstn_in), .bus(ch_b.chan));

  // Pins not selected are released and held low
  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      port_pin_zero_out     <= 1'b0;
      port_pin_zero_oe_out  <= 1'b0;
      port_pin_one_out      <= 1'b0;
      port_pin_one_oe_out   <= 1'b0;
      port_pin_two_out      <= 1'b0;
      port_pin_two_oe_out   <= 1'b0;
      port_pin_three_out    <= 1'b0;
      port_pin_three_oe_out <= 1'b0;
      slow_osc_clock_out    <= 1'b0;
      fast_osc_ready_out    <= 1'b0;
    end
    else
    begin
      port_pin_zero_oe_out  <= ch_a.enable && !cfg_chan_a[`DPO_CH_PIN_BIT];
      port_pin_zero_out     <= ch_a.pulse && !cfg_chan_a[`DPO_CH_PIN_BIT];
      port_pin_two_oe_out   <= ch_a.enable && cfg_chan_a[`DPO_CH_PIN_BIT];
      port_pin_two_out      <= ch_a.pulse && cfg_chan_a[`DPO_CH_PIN_BIT];
      port_pin_one_oe_out   <= ch_b.enable && !cfg_chan_b[`DPO_CH_PIN_BIT];
      port_pin_one_out      <= ch_b.pulse && !cfg_chan_b[`DPO_CH_PIN_BIT];
      port_pin_three_oe_out <= ch_b.enable && cfg_chan_b[`DPO_CH_PIN_BIT];
      port_pin_three_out    <= ch_b.pulse && cfg_chan_b[`DPO_CH_PIN_BIT];
      slow_osc_clock_out    <= slow_tick;
      fast_osc_ready_out    <= fast_state == DPO_FO_RUN;
    end
  end
endmodule // dpo_top

// file: hdl/dpo_consts.svh
`ifndef DPO_CONSTS_SVH
`define DPO_CONSTS_SVH
// Processor write addresses of the two level cells
`define DPO_ADDR_LEVEL_A 7'h6d
`define DPO_ADDR_LEVEL_B 7'h6e
// Configuration register numbers
`define DPO_CFG_OSC    6'h1b
`define DPO_CFG_CHAN_A 6'h1d
`define DPO_CFG_CHAN_B 6'h1e
`define DPO_CFG_RES    6'h1f
`define DPO_CFG_CLK    6'h20
`define DPO_CFG_STAT   6'h21
// Field positions
`define DPO_OSC_CTUNE_LSB 0
`define DPO_OSC_FTUNE_LSB 2
`define DPO_OSC_RUN_LSB   5
`define DPO_OSC_DIV4_BIT  8
`define DPO_CH_EN_BIT     0
`define DPO_CH_PDM_BIT    1
`define DPO_CH_PIN_BIT    2
`define DPO_RES_LSB       0
`define DPO_CLK_SRC_BIT   0
`define DPO_CLK_PRE_LSB   1
// Reset values
`define DPO_CFG_OSC_RST  16'h0000
`define DPO_CFG_CHAN_RST 16'h0000
`define DPO_CFG_RES_RST  16'h000a
`define DPO_CFG_CLK_RST  16'h0000
`define DPO_LEVEL_RST    16'h0000
// Timing, frequencies in Hz
`define DPO_MCLK_HZ   25000000
`define DPO_F_5K      5000
`define DPO_F_10K     10000
`define DPO_F_28K     28000
`define DPO_F_48K     48000
`define DPO_F_50K     50000
`define DPO_F_100K    100000
`define DPO_F_200K    200000
`define DPO_FAST_HZ   2000000
`define DPO_FRAC_HZ   1000000
`define DPO_FAST_STEP (`DPO_FAST_HZ / `DPO_FRAC_HZ)
`define DPO_FAST_MOD  (`DPO_MCLK_HZ / `DPO_FRAC_HZ)
`define DPO_LAT_1     1
`define DPO_LAT_2     2
`define DPO_LAT_31    31
`define DPO_RES_MIN   10
`define DPO_RES_MAX   16
`endif

// file: hdl/dpo_pkg.sv
package dpo_pkg;
  typedef logic [15:0] dpo_word_t;
  typedef logic [4:0]  dpo_res_t;
  typedef enum logic [1:0] {DPO_FO_OFF, DPO_FO_WAIT, DPO_FO_RUN} dpo_fast_state_t;

  // Mask of the low res bits
  function automatic dpo_word_t dpo_res_mask(input dpo_res_t res);
    dpo_res_mask = 16'hffff >> (5'd16 - res);
  endfunction
endpackage

// file: hdl/dpo_chan_if.sv
`timescale 1ns/1ps
interface dpo_chan_if;
  logic              tick;
  logic              enable;
  logic              pdm_mode;
  dpo_pkg::dpo_res_t res;
  dpo_pkg::dpo_word_t level;
  logic              pulse;
  modport ctrl (output tick, output enable, output pdm_mode, output res, output level,
                input pulse);
  modport chan (input tick, input enable, input pdm_mode, input res, input level,
                output pulse);
endinterface

// file: hdl/dpo_chan.sv
`timescale 1ns/1ps
module dpo_chan
(
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic rstn_in,
  // Control and pulse
  dpo_chan_if.chan  bus
);
  import dpo_pkg::*;

  dpo_word_t cnt;
  dpo_word_t acc;
  logic      pulse;
  dpo_word_t next_cnt;
  dpo_word_t next_acc;
  logic      next_pulse;
  dpo_word_t mask;
  dpo_word_t lvl;
  logic [16:0] sum;
  logic      over;

  // Period counter, accumulator and output bit
  always_comb
  begin
    mask       = dpo_res_mask(bus.res);
    lvl        = bus.level & mask;
    sum        = {1'b0, acc} + {1'b0, lvl};
    over       = sum > {1'b0, mask};
    next_cnt   = cnt;
    next_acc   = acc;
    next_pulse = pulse;
    if (!bus.enable)
    begin
      next_cnt   = 16'h0000;
      next_acc   = 16'h0000;
      next_pulse = 1'b0;
    end
    else if (bus.tick)
    begin
      next_cnt = (cnt + 16'h0001) & mask;
      // Carry out of a res-bit accumulator spreads highs evenly
      next_acc = over ? (sum[15:0] - mask - 16'h0001) : sum[15:0];
      if (lvl == mask)
        next_pulse = 1'b1;
      else if (lvl == 16'h0000)
        next_pulse = 1'b0;
      else if (bus.pdm_mode)
        next_pulse = over;
      else
        next_pulse = cnt < lvl;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      cnt   <= 16'h0000;
      acc   <= 16'h0000;
      pulse <= 1'b0;
    end
    else
    begin
      cnt   <= next_cnt;
      acc   <= next_acc;
      pulse <= next_pulse;
    end
  end

  assign bus.pulse = pulse;
endmodule // dpo_chan

// file: testbench/dpo_top_props.sv
`timescale 1ns/1ps
`include "dpo_consts.svh"
// ****************************************
// Port checker for the pulse output block
// ****************************************
module dpo_top_props
#(
  parameter int unsigned SLOW_DIV_5K = 5000
)
(
  // Clock and reset
  input  wire logic               mclk_in,
  input  wire logic               rstn_in,
  // Configuration port
  input  wire logic               cfg_wr_in,
  input  wire logic               cfg_rd_in,
  input  wire logic [5:0]         cfg_addr_in,
  input  wire dpo_pkg::dpo_word_t cfg_wdata_in,
  input  wire logic [15:0]        cfg_rdata_out,
  input  wire logic               cfg_rvalid_out,
  // Oscillators and pin enables
  input  wire logic               slow_osc_clock_out,
  input  wire logic               fast_osc_ready_out,
  input  wire logic               port_pin_zero_oe_out,
  input  wire logic               port_pin_one_oe_out,
  input  wire logic               port_pin_two_oe_out,
  input  wire logic               port_pin_three_oe_out
);
  import dpo_pkg::*;
  // Longest legal slow period, whichever trim is set
  localparam int unsigned GAP_MAX = (SLOW_DIV_5K > 5000) ? SLOW_DIV_5K : 5000;
  logic [15:0] slow_gap;
  logic [15:0] next_slow_gap;
  logic        osc_wr;

  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  assign osc_wr = cfg_wr_in && (cfg_addr_in == `DPO_CFG_OSC);

  // Cycles since the last slow tick; a stopped oscillator shows up here
  always_comb
  begin
    next_slow_gap = slow_osc_clock_out ? 16'h0000 : slow_gap + 16'h0001;
  end

  always_ff @(posedge mclk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      slow_gap <= 16'h0000;
    else
      slow_gap <= next_slow_gap;
  end

  AST_RVALID: assert property (cfg_rd_in |=> cfg_rvalid_out)
    else $error("read strobe not answered");
  AST_RDATA_IDLE: assert property (!cfg_rd_in |=> !cfg_rvalid_out && cfg_rdata_out == 16'h0000)
    else $error("read data outside a read");
  AST_RES_RANGE: assert property (cfg_rd_in && cfg_addr_in == `DPO_CFG_RES
    |=> cfg_rdata_out >= 16'h000a && cfg_rdata_out <= 16'h0010) else $error("resolution out of range");
  AST_ROUTE_A: assert property (cfg_wr_in && cfg_addr_in == `DPO_CFG_CHAN_A |-> ##2
    port_pin_zero_oe_out == ($past(cfg_wdata_in[0], 2) && !$past(cfg_wdata_in[2], 2))
    && port_pin_two_oe_out == ($past(cfg_wdata_in[0], 2) && $past(cfg_wdata_in[2], 2)))
    else $error("channel a routing wrong");
  AST_ROUTE_B: assert property (cfg_wr_in && cfg_addr_in == `DPO_CFG_CHAN_B |-> ##2
    port_pin_one_oe_out == ($past(cfg_wdata_in[0], 2) && !$past(cfg_wdata_in[2], 2))
    && port_pin_three_oe_out == ($past(cfg_wdata_in[0], 2) && $past(cfg_wdata_in[2], 2)))
    else $error("channel b routing wrong");
  AST_PIN_EXCL: assert property (!(port_pin_zero_oe_out && port_pin_two_oe_out)
    && !(port_pin_one_oe_out && port_pin_three_oe_out)) else $error("channel on two pins");
  AST_SLOW_RUNS: assert property (slow_gap <= GAP_MAX)
    else $error("slow oscillator stopped");
  AST_READY_OFF: assert property (osc_wr && cfg_wdata_in[7:5] == 3'h0
    |-> ##3 !fast_osc_ready_out) else $error("fast oscillator not off");
  AST_READY_NOW: assert property (osc_wr && cfg_wdata_in[7:5] == 3'h1
    |-> ##[1:4] fast_osc_ready_out) else $error("fast oscillator not running");
  AST_READY_WAIT: assert property (osc_wr && cfg_wdata_in[7:5] == 3'h2 && !fast_osc_ready_out
    |-> ##3 !fast_osc_ready_out [*5]) else $error("latency skipped");
endmodule // dpo_top_props

bind dpo_top dpo_top_props #(.SLOW_DIV_5K(SLOW_DIV_5K)) i_props
(
  .mclk_in, .rstn_in, .cfg_wr_in, .cfg_rd_in, .cfg_addr_in, .cfg_wdata_in, .cfg_rdata_out,
  .cfg_rvalid_out, .slow_osc_clock_out, .fast_osc_ready_out, .port_pin_zero_oe_out,
  .port_pin_one_oe_out, .port_pin_two_oe_out, .port_pin_three_oe_out
);

// file: testbench/dpo_rc_model.sv
`timescale 1ns/1ps
// ****************************************
// First-order RC filter on one pulse pin
// ****************************************
module dpo_rc_model
(
  // Pin from the block
  input  wire logic        mclk_in,
  input  wire logic        pin_in,
  input  wire logic        pin_oe_in,
  // Filtered voltage, full scale is the supply
  output logic [15:0]      volt_out
);
  logic [15:0] target;

  initial volt_out = 16'h0000;
  // A released pin has no pull, so it shows the inverse of its level
  assign target = (pin_oe_in ? pin_in : ~pin_in) ? 16'hffff : 16'h0000;
  // Tau of 64 clocks: fast settling traded for ripple
  always @(posedge mclk_in)
    volt_out <= volt_out + 16'((int'(target) - int'(volt_out)) >>> 6);
endmodule // dpo_rc_model

// file: testbench/dpo_top_tb.sv
`timescale 1ns/1ps
`include "dpo_consts.svh"
// ****************************************
// Testbench for the pulse output block
// ****************************************
module dpo_top_tb;
  import dpo_pkg::*;
  localparam int unsigned SLOW_DIV = 8;
  logic        mclk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        proc_wr_in = 1'b0;
  logic [6:0]  proc_addr_in = 7'h00;
  dpo_word_t   proc_data_in = 16'h0000;
  logic        cfg_wr_in = 1'b0;
  logic        cfg_rd_in = 1'b0;
  logic [5:0]  cfg_addr_in = 6'h00;
  dpo_word_t   cfg_wdata_in = 16'h0000;
  logic [15:0] cfg_rdata_out;
  logic        cfg_rvalid_out;
  logic        slow_osc_clock_out;
  logic        fast_osc_ready_out;
  logic [3:0]  pin;
  logic [3:0]  oe;
  logic [15:0] volt;
  logic [15:0] rd;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cycles = 0;
  int          first;
  int          gap;
  int          hi;
  logic [5:0]  reg_num [7] = '{6'h1b, 6'h1c, 6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h21};
  logic [15:0] reg_rst [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000a, 16'h0000, 16'h0000};
  logic [2:0]  run_code [6] = '{3'h6, 3'h3, 3'h2, 3'h1, 3'h0, 3'h4};
  int          run_lat [6] = '{1, 2, 31, 0, -1, -1};
  logic [15:0] lvl_a [3] = '{16'h0000, 16'h03ff, 16'h1500};
  int          hi_a [3] = '{0, 8192, 2048};

  dpo_top #(.SLOW_DIV_5K(SLOW_DIV)) i_dut
  (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .proc_wr_in(proc_wr_in), .proc_addr_in(proc_addr_in),
    .proc_data_in(proc_data_in), .cfg_wr_in(cfg_wr_in), .cfg_rd_in(cfg_rd_in),
    .cfg_addr_in(cfg_addr_in), .cfg_wdata_in(cfg_wdata_in), .cfg_rdata_out(cfg_rdata_out),
    .cfg_rvalid_out(cfg_rvalid_out), .slow_osc_clock_out(slow_osc_clock_out),
    .fast_osc_ready_out(fast_osc_ready_out), .port_pin_zero_out(pin[0]),
    .port_pin_zero_oe_out(oe[0]), .port_pin_one_out(pin[1]), .port_pin_one_oe_out(oe[1]),
    .port_pin_two_out(pin[2]), .port_pin_two_oe_out(oe[2]), .port_pin_three_out(pin[3]),
    .port_pin_three_oe_out(oe[3])
  );

  dpo_rc_model i_rc (.mclk_in(mclk_in), .pin_in(pin[0]), .pin_oe_in(oe[0]), .volt_out(volt));

  // Clock and hang guard; the longest legal run is about 50k cycles
  always #20 mclk_in = ~mclk_in;
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 70000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Waits end just past an edge so outputs have settled
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge mclk_in);
    #1;
  endtask

  task automatic cfg_wr(input logic [5:0] a, input dpo_word_t d);
    @(posedge mclk_in);
    cfg_wr_in <= 1'b1;
    cfg_addr_in <= a;
    cfg_wdata_in <= d;
    @(posedge mclk_in);
    cfg_wr_in <= 1'b0;
  endtask

  task automatic cfg_rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge mclk_in);
    cfg_rd_in <= 1'b1;
    cfg_addr_in <= a;
    @(posedge mclk_in);
    cfg_rd_in <= 1'b0;
    #1;
    check({15'h0000, cfg_rvalid_out}, 16'h0001);
    d = cfg_rdata_out;
  endtask

  task automatic proc_wr(input logic [6:0] a, input dpo_word_t d);
    @(posedge mclk_in);
    proc_wr_in <= 1'b1;
    proc_addr_in <= a;
    proc_data_in <= d;
    @(posedge mclk_in);
    proc_wr_in <= 1'b0;
  endtask

  // High cycles on one pin over a whole number of periods
  task automatic count_high(input int idx, input int n, output int h);
    h = 0;
    repeat (n)
    begin
      @(posedge mclk_in);
      #1;
      if (pin[idx] === 1'b1)
        h++;
    end
  endtask

  // Length of the next high run on one pin, in clock cycles
  task automatic run_len(input int idx, output int n);
    n = 0;
    @(posedge pin[idx]);
    while (pin[idx] === 1'b1)
    begin
      wait_cycles(1);
      n++;
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge mclk_in);
    rstn_in <= 1'b1;
    check({12'h000, oe}, 16'h0000);
    cfg_wr(`DPO_CFG_STAT, 16'hffff);
    for (int i = 0; i < 7; i++)
    begin
      cfg_rd(reg_num[i], rd);
      check(rd, reg_rst[i]);
    end
    // Slow trim 3/1 gives the shortest period here, SLOW_DIV cycles
    cfg_wr(`DPO_CFG_OSC, 16'h0007);
    cfg_rd(`DPO_CFG_OSC, rd);
    check(rd, 16'h0007);
    wait_cycles(20);
    first = -1;
    gap = 0;
    for (int i = 0; i < 200 && gap == 0; i++)
    begin
      wait_cycles(1);
      if (slow_osc_clock_out === 1'b1)
        if (first >= 0)
          gap = i - first;
        else
          first = i;
    end
    check(16'(gap), 16'(SLOW_DIV));
    // Each run code starts from off so it restarts the latency
    for (int i = 0; i < 6; i++)
    begin
      cfg_wr(`DPO_CFG_OSC, 16'h0007);
      wait_cycles(4);
      cfg_wr(`DPO_CFG_OSC, 16'h0007 | (16'(run_code[i]) << 5));
      if (run_lat[i] > 1)
      begin
        wait_cycles((run_lat[i] - 1) * SLOW_DIV - 3);
        check({15'h0000, fast_osc_ready_out}, 16'h0000);
      end
      wait_cycles((run_lat[i] + 1) * SLOW_DIV + 4);
      check({15'h0000, fast_osc_ready_out}, (run_lat[i] >= 0) ? 16'h0001 : 16'h0000);
      cfg_rd(`DPO_CFG_STAT, rd);
      check(rd, (run_lat[i] >= 0) ? 16'h0003 : 16'h0000);
    end
    // Channel a, width mode, slow base, resolution 10, upper level bits masked
    cfg_wr(`DPO_CFG_OSC, 16'h0007);
    cfg_wr(`DPO_CFG_CHAN_A, 16'h0001);
    wait_cycles(3);
    check({12'h000, oe}, 16'h0001);
    for (int i = 0; i < 3; i++)
    begin
      proc_wr(`DPO_ADDR_LEVEL_A, lvl_a[i]);
      wait_cycles(8);
      count_high(0, 8192, hi);
      check(16'(hi), 16'(hi_a[i]));
      if (i == 1)
        check({15'h0000, volt > 16'hf000}, 16'h0001);
    end
    // Channel b alone, density mode on pin three
    cfg_wr(`DPO_CFG_CHAN_B, 16'h0007);
    cfg_wr(`DPO_CFG_CHAN_A, 16'h0000);
    proc_wr(`DPO_ADDR_LEVEL_B, 16'h0100);
    wait_cycles(8);
    check({12'h000, oe}, 16'h0008);
    count_high(3, 8192, hi);
    check(16'(hi), 16'h0800);
    // Resolution 11, with a stray write next to the level cells
    cfg_wr(`DPO_CFG_RES, 16'h000b);
    cfg_rd(`DPO_CFG_RES, rd);
    check(rd, 16'h000b);
    proc_wr(`DPO_ADDR_LEVEL_B, 16'h0400);
    proc_wr(7'h6f, 16'h07ff);
    wait_cycles(8);
    count_high(3, 16384, hi);
    check(16'(hi), 16'h2000);
    // Resolution clamp, quartered fast base, prescale 2, other pins
    cfg_wr(`DPO_CFG_RES, 16'h0005);
    cfg_rd(`DPO_CFG_RES, rd);
    check(rd, 16'h000a);
    cfg_wr(`DPO_CFG_OSC, 16'h0127);
    cfg_wr(`DPO_CFG_CLK, 16'h0003);
    cfg_wr(`DPO_CFG_CHAN_A, 16'h0007);
    cfg_wr(`DPO_CFG_CHAN_B, 16'h0003);
    proc_wr(`DPO_ADDR_LEVEL_B, 16'h0200);
    wait_cycles(2);
    check({12'h000, oe}, 16'h0006);
    run_len(2, hi);
    check(16'(hi), 16'(8 * `DPO_MCLK_HZ / `DPO_FAST_HZ));
    run_len(1, hi);
    check(16'(hi), 16'(8 * `DPO_MCLK_HZ / `DPO_FAST_HZ));
    stop_test();
  end
endmodule // dpo_top_tb
